// >>> src/dmamc_top.sv
// Top level: APB register file, system error flag, interrupts and four channels
// =====================================================================
// Overview of operation
// - Bit 30 zero enables acknowledge strobe
// - Dual address mode ignores acknowledge enable
// - Bit 29 zero enables transfer end strobe
// - Bit 27 picks low level or falling edge
// - First request after enable taken on level
// - Bit 26 delays next acceptance one cycle
// - Bits 25, 24, 22-20 read zero
// - Bit 23 shows channel active, read only
// - Channel 0 bit 19 flags system errors
// - Error flag locks every transfer enable write
// - Bit 19 reads zero in channels 1-3
// - Flag cleared by zero after reading one
// - Errors in module stop leave flag alone
// - Bit 31 enables the channel's transfers
//
// The APB register port and the register offsets were chosen for this implementation.
module dmamc_top
  import dmamc_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [7:0]          i_paddr,
  input  wire logic [31:0]         i_pwdata,
  output logic      [31:0]         o_prdata,
  output logic                     o_pready,
  output logic                     o_pslverr,
  input  wire logic                i_addr_error,
  input  wire logic                i_nmi,
  input  wire logic [NUM_CH-1:0]   i_external_transfer_request_n,
  output logic      [NUM_CH-1:0]   o_transfer_acknowledge_strobe_n,
  output logic      [NUM_CH-1:0]   o_transfer_end_strobe_n,
  output logic                     o_irq
);
  import dmamc_pkg::*;

  logic [NUM_CH-1:0] enable_reg;
  logic [NUM_CH-1:0] ack_off_reg;
  logic [NUM_CH-1:0] end_off_reg;
  logic [NUM_CH-1:0] rsvd_reg;
  logic [NUM_CH-1:0] edge_reg;
  logic [NUM_CH-1:0] delay_reg;
  logic [NUM_CH-1:0] dual_reg;
  logic              stop_reg;
  logic              err_reg;
  logic              err_seen_reg;
  logic [7:0]        irq_stat_reg;
  logic [7:0]        irq_en_reg;
  logic [NUM_CH-1:0] req_sync;
  logic [NUM_CH-1:0] active;
  logic [NUM_CH-1:0] done;
  logic [NUM_CH-1:0] ack_n;
  logic [NUM_CH-1:0] end_n;
  logic              wr;
  logic              rd;
  logic              hit_ch;
  logic [1:0]        ch_idx;
  logic              sys_evt;
  logic [7:0]        irq_set;

  // =====================================================================
  // APB decode: every access completes with no wait state
  assign wr     = i_psel && i_penable && i_pwrite;
  assign rd     = i_psel && i_penable && !i_pwrite;
  assign hit_ch = (i_paddr[7:4] == 4'h0) && (i_paddr[1:0] == 2'h0);
  assign ch_idx = i_paddr[3:2];
  // Error events during module stop are dropped
  assign sys_evt = (i_addr_error || i_nmi) && !stop_reg;

  function automatic logic [31:0] mode_word(input int unsigned c);
    logic [31:0] w;
    w = MODE_CTRL_RESET;
    w[BIT_TRANSFER_EN] = enable_reg[c];
    w[BIT_ACK_OE]      = ack_off_reg[c];
    w[BIT_END_OE]      = end_off_reg[c];
    w[BIT_RSVD28]      = rsvd_reg[c];
    w[BIT_REQ_DETECT]  = edge_reg[c];
    w[BIT_NEXT_DELAY]  = delay_reg[c];
    w[BIT_ACTIVE]      = active[c];
    w[BIT_SYS_ERR]     = (c == 0) ? err_reg : 1'b0;
    return w;
  endfunction

  dmamc_sync #(
    .W(NUM_CH)
  ) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_external_transfer_request_n),
    .o_sync    (req_sync)
  );

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    dmamc_channel u_ch (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_enable     (enable_reg[g]),
      .i_edge_mode  (edge_reg[g]),
      .i_next_delay (delay_reg[g]),
      .i_ack_off    (ack_off_reg[g]),
      .i_end_off    (end_off_reg[g]),
      .i_dual_addr  (dual_reg[g]),
      .i_req_n      (req_sync[g]),
      .o_active     (active[g]),
      .o_ack_n      (ack_n[g]),
      .o_end_n      (end_n[g]),
      .o_done       (done[g])
    );
  end

  // =====================================================================
  // Mode control fields
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_off_reg <= '0;
      end_off_reg <= '0;
      rsvd_reg    <= '0;
      edge_reg    <= '0;
      delay_reg   <= '0;
    end else if (wr && hit_ch) begin
      ack_off_reg[ch_idx] <= i_pwdata[BIT_ACK_OE];
      end_off_reg[ch_idx] <= i_pwdata[BIT_END_OE];
      rsvd_reg[ch_idx]    <= i_pwdata[BIT_RSVD28];
      edge_reg[ch_idx]    <= i_pwdata[BIT_REQ_DETECT];
      delay_reg[ch_idx]   <= i_pwdata[BIT_NEXT_DELAY];
    end
  end

  // Transfer enable; a system error both clears and locks it
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      enable_reg <= '0;
    end else if (sys_evt) begin
      enable_reg <= '0;
    end else if (wr && hit_ch && !err_reg) begin
      enable_reg[ch_idx] <= i_pwdata[BIT_TRANSFER_EN];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dual_reg <= '0;
      stop_reg <= 1'b0;
    end else if (wr && i_paddr == OFF_MODE_SEL) begin
      dual_reg <= i_pwdata[NUM_CH-1:0];
      stop_reg <= i_pwdata[BIT_MODULE_STOP];
    end
  end

  // =====================================================================
  // System error flag: read-as-one then write-zero clears; set wins
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      err_reg      <= 1'b0;
      err_seen_reg <= 1'b0;
    end else if (sys_evt) begin
      err_reg      <= 1'b1;
      err_seen_reg <= 1'b0;
    end else if (wr && i_paddr == OFF_MODE_CTRL0 && !i_pwdata[BIT_SYS_ERR] && err_seen_reg) begin
      err_reg      <= 1'b0;
      err_seen_reg <= 1'b0;
    // Arm on the data returned, so a read racing a new error does not arm
    end else if (rd && i_paddr == OFF_MODE_CTRL0 && o_prdata[BIT_SYS_ERR]) begin
      err_seen_reg <= 1'b1;
    end
  end

  // =====================================================================
  // Interrupts: sticky status, enable mask, write-one clear
  assign irq_set = {done, 3'h0, sys_evt};

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_stat_reg <= 8'h00;
    end else if (wr && i_paddr == OFF_IRQ_CLEAR) begin
      irq_stat_reg <= (irq_stat_reg & ~i_pwdata[7:0]) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_en_reg <= 8'h00;
    end else if (wr && i_paddr == OFF_IRQ_ENABLE) begin
      irq_en_reg <= i_pwdata[7:0] & IRQ_WMASK;
    end
  end

  // =====================================================================
  // Registered outputs
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq                           <= 1'b0;
      o_transfer_acknowledge_strobe_n <= '1;
      o_transfer_end_strobe_n         <= '1;
    end else begin
      o_irq                           <= |(irq_stat_reg & irq_en_reg);
      o_transfer_acknowledge_strobe_n <= ack_n;
      o_transfer_end_strobe_n         <= end_n;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      if (i_psel && !i_penable && !i_pwrite) begin
        if (hit_ch) begin
          o_prdata <= mode_word(32'(ch_idx));
        end else if (i_paddr == OFF_IRQ_STATUS) begin
          o_prdata <= {24'h0, irq_stat_reg};
        end else if (i_paddr == OFF_IRQ_ENABLE) begin
          o_prdata <= {24'h0, irq_en_reg};
        end else if (i_paddr == OFF_MODE_SEL) begin
          o_prdata <= {27'h0, stop_reg, dual_reg};
        end else if (i_paddr != OFF_IRQ_CLEAR) begin
          o_pslverr <= 1'b1;
        end
      end else if (i_psel && !i_penable && i_pwrite) begin
        o_pslverr <= !(hit_ch || i_paddr == OFF_IRQ_ENABLE ||
                       i_paddr == OFF_IRQ_CLEAR || i_paddr == OFF_MODE_SEL);
      end
    end
  end

  // =====================================================================
  // Assertions
  a_err_locks_enable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (err_reg && !sys_evt) |=> $stable(enable_reg))
    else $error("transfer enable changed while error flag set");

  a_stop_keeps_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (stop_reg && !err_reg && !(rd || wr)) |=> !err_reg)
    else $error("error flag set during module stop");

  a_err_sets_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    sys_evt |=> err_reg && enable_reg == '0)
    else $error("system error did not set flag and stop channels");

  a_clear_needs_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (err_reg && !err_seen_reg) |=> err_reg)
    else $error("error flag cleared without prior read");

  a_upper_bit19_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_pready && $past(hit_ch && ch_idx != 2'h0 && !i_pwrite)) |-> !o_prdata[BIT_SYS_ERR])
    else $error("bit 19 read nonzero in channels 1 to 3");

  a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_pready && $past(hit_ch && !i_pwrite)) |->
      (o_prdata[25:24] == 2'h0 && o_prdata[22:20] == 3'h0))
    else $error("reserved bits read nonzero");

  a_write_no_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!err_reg && !sys_evt) |=> !err_reg)
    else $error("error flag set without a system error");

  a_read_then_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (wr && i_paddr == OFF_MODE_CTRL0 && !i_pwdata[BIT_SYS_ERR] && err_seen_reg && !sys_evt)
    |=> !err_reg)
    else $error("armed clearing write left the error flag set");

  a_arm_needs_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!err_seen_reg && !(rd && i_paddr == OFF_MODE_CTRL0)) |=> !err_seen_reg)
    else $error("clear armed without a read of the flag");

  a_err_irq_bit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    sys_evt |=> irq_stat_reg[IRQ_ERR_BIT])
    else $error("system error did not raise its interrupt status");

  a_ack_disabled: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    &(o_transfer_acknowledge_strobe_n | ~$past(ack_off_reg | dual_reg, 2)))
    else $error("acknowledge strobe driven while disabled");

  a_end_disabled: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    &(o_transfer_end_strobe_n | ~$past(end_off_reg, 2)))
    else $error("transfer end strobe driven while disabled");

  a_ack_when_active: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    &(o_transfer_acknowledge_strobe_n | $past(active)))
    else $error("acknowledge strobe outside an active transfer");

  a_irq_set_wins: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (irq_set != 8'h00) |=> (irq_stat_reg & $past(irq_set)) == $past(irq_set))
    else $error("interrupt event lost against a clear");

  a_irq_mask_bits: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (irq_en_reg & ~IRQ_WMASK) == 8'h00)
    else $error("unused interrupt enable bit set");

  a_pready_single: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_pready |=> !o_pready)
    else $error("ready held for more than one cycle");

  a_slverr_with_ready: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_pslverr |-> o_pready)
    else $error("error response outside the access cycle");

  a_rdata_idle_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data not zero outside the access cycle");
endmodule : dmamc_top

// >>> src/dmamc_pkg.sv
// Package: register map, bit positions and enumerations for the DMA mode control block
package dmamc_pkg;
  // =====================================================================
  // Register map
  localparam int unsigned NUM_CH            = 4;
  localparam logic [7:0]  OFF_MODE_CTRL0    = 8'h00;
  localparam logic [7:0]  OFF_MODE_CTRL1    = 8'h04;
  localparam logic [7:0]  OFF_MODE_CTRL2    = 8'h08;
  localparam logic [7:0]  OFF_MODE_CTRL3    = 8'h0c;
  localparam logic [7:0]  OFF_IRQ_STATUS    = 8'h10;
  localparam logic [7:0]  OFF_IRQ_ENABLE    = 8'h14;
  localparam logic [7:0]  OFF_IRQ_CLEAR     = 8'h18;
  localparam logic [7:0]  OFF_MODE_SEL      = 8'h1c;
  // =====================================================================
  // Bit positions of the mode control register
  localparam int unsigned BIT_TRANSFER_EN   = 31;
  localparam int unsigned BIT_ACK_OE        = 30;
  localparam int unsigned BIT_END_OE        = 29;
  localparam int unsigned BIT_RSVD28        = 28;
  localparam int unsigned BIT_REQ_DETECT    = 27;
  localparam int unsigned BIT_NEXT_DELAY    = 26;
  localparam int unsigned BIT_ACTIVE        = 23;
  localparam int unsigned BIT_SYS_ERR       = 19;
  // Mode select register: bit n set means channel n is in dual address mode
  localparam int unsigned BIT_MODULE_STOP   = 4;
  // Interrupt status layout: bit 0 system error, bits 4..7 transfer end per channel
  localparam int unsigned IRQ_ERR_BIT       = 0;
  localparam int unsigned IRQ_END_BASE      = 4;
  localparam logic [31:0] MODE_CTRL_RESET   = 32'h0000_0000;
  localparam logic [7:0]  IRQ_WMASK         = 8'hf1;
  // Duration of one transfer in clock cycles
  localparam int unsigned XFER_CYCLES       = 2;
  typedef enum logic [1:0] {
    DMAMC_IDLE,
    DMAMC_XFER,
    DMAMC_GAP
  } dmamc_state_e;
endpackage : dmamc_pkg

// >>> src/dmamc_sync.sv
// Two-stage synchroniser for the external request pins
module dmamc_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] stage1_reg;
  // =====================================================================
  // Pins idle high (request is active low), so reset to all ones
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage1_reg <= '1;
      o_sync     <= '1;
    end else begin
      stage1_reg <= i_async;
      o_sync     <= stage1_reg;
    end
  end
endmodule : dmamc_sync

// >>> src/dmamc_channel.sv
// One DMA channel: request detection, transfer sequencing and strobe outputs
module dmamc_channel
  import dmamc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_enable,
  input  wire logic i_edge_mode,
  input  wire logic i_next_delay,
  input  wire logic i_ack_off,
  input  wire logic i_end_off,
  input  wire logic i_dual_addr,
  input  wire logic i_req_n,
  output logic      o_active,
  output logic      o_ack_n,
  output logic      o_end_n,
  output logic      o_done
);
  dmamc_state_e state_reg;
  logic [1:0]   cnt_reg;
  logic         req_prev_reg;
  logic         first_reg;
  logic         req_hit;
  logic         last;

  // =====================================================================
  // Request detection
  assign req_hit = !i_req_n && (!i_edge_mode || first_reg || req_prev_reg);
  assign last    = (cnt_reg == 2'(XFER_CYCLES - 1));

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      req_prev_reg <= 1'b1;
    end else begin
      req_prev_reg <= i_req_n;
    end
  end

  // First request after enabling is taken on level
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      first_reg <= 1'b1;
    end else if (!i_enable) begin
      first_reg <= 1'b1;
    end else if (state_reg == DMAMC_IDLE && req_hit) begin
      first_reg <= 1'b0;
    end
  end

  // =====================================================================
  // Transfer sequencing
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= DMAMC_IDLE;
      cnt_reg   <= 2'h0;
    end else begin
      case (state_reg)
        DMAMC_IDLE: begin
          cnt_reg <= 2'h0;
          if (i_enable && req_hit) begin
            state_reg <= DMAMC_XFER;
          end
        end
        DMAMC_XFER: begin
          cnt_reg <= cnt_reg + 2'h1;
          if (last) begin
            state_reg <= i_next_delay ? DMAMC_GAP : DMAMC_IDLE;
          end
        end
        DMAMC_GAP: begin
          state_reg <= DMAMC_IDLE;
        end
        default: begin
          state_reg <= DMAMC_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // Status and strobes, all registered
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_active <= 1'b0;
      o_ack_n  <= 1'b1;
      o_end_n  <= 1'b1;
      o_done   <= 1'b0;
    end else begin
      o_active <= (state_reg == DMAMC_IDLE) ? (i_enable && req_hit) :
                  (state_reg == DMAMC_XFER && !last);
      // Dual address mode never drives the acknowledge pin
      o_ack_n  <= !((state_reg == DMAMC_IDLE && i_enable && req_hit) ||
                    (state_reg == DMAMC_XFER && !last)) ||
                  i_ack_off || i_dual_addr;
      o_end_n  <= !(state_reg == DMAMC_XFER && cnt_reg == 2'(XFER_CYCLES - 2)) ||
                  i_end_off;
      o_done   <= (state_reg == DMAMC_XFER) && last;
    end
  end

  a_gap_holds_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_reg == DMAMC_XFER && last && i_next_delay) |=> ##1 state_reg == DMAMC_IDLE)
    else $error("delayed acceptance did not return to idle after one cycle");
  a_no_delay_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_reg == DMAMC_XFER && last && !i_next_delay) |=> state_reg == DMAMC_IDLE)
    else $error("immediate acceptance did not return to idle");
  a_dual_no_ack: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $past(i_dual_addr) |-> o_ack_n)
    else $error("acknowledge driven in dual address mode");
  a_edge_needs_fall: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_reg == DMAMC_IDLE && i_enable && i_edge_mode && !first_reg && !req_prev_reg)
    |=> state_reg == DMAMC_IDLE)
    else $error("held low level accepted in edge mode");
endmodule : dmamc_channel

// >>> testbench/dmamc_peripheral.sv
// Requesting peripheral model that drives the active-low request pins
module dmamc_peripheral
  import dmamc_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic [NUM_CH-1:0] i_want,
  output logic      [NUM_CH-1:0] o_req_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // =====================================================================
  // Request pins
  // Pins idle high, as a pulled-up pin would, whenever no request is wanted
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_req_n <= '1;
    end else begin
      o_req_n <= ~i_want;
    end
  end
endmodule // dmamc_peripheral

// >>> testbench/dmamc_top_test.sv
// Testbench for the DMA mode control block: APB sequences with expected values
module dmamc_top_test;
  import dmamc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // =====================================================================
  // Signals
  logic              clk;
  logic              rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              addr_err;
  logic              nmi;
  logic [NUM_CH-1:0] want;
  logic [NUM_CH-1:0] req_n;
  logic [NUM_CH-1:0] ack_n;
  logic [NUM_CH-1:0] end_n;
  logic              irq;
  logic [31:0]       q;
  logic              slv;
  logic              act;
  int                n_errors;
  int                tests_run;
  int                cyc;
  int                p0;
  int                ack_cnt [NUM_CH];
  int                end_cnt [NUM_CH];
  int                last_end [NUM_CH];
  int                period [NUM_CH];
  // =====================================================================
  // Instances
  dmamc_top dmamc_top_i (
    .i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_addr_error(addr_err), .i_nmi(nmi),
    .i_external_transfer_request_n(req_n), .o_transfer_acknowledge_strobe_n(ack_n),
    .o_transfer_end_strobe_n(end_n), .o_irq(irq)
  );
  dmamc_peripheral dmamc_peripheral_i (
    .i_clk(clk), .i_sys_rst(rst), .i_want(want), .o_req_n(req_n)
  );
  // =====================================================================
  // Clock and strobe monitor
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    for (int c = 0; c < NUM_CH; c++) begin
      if (ack_n[c] === 1'b0) ack_cnt[c]++;
      if (end_n[c] === 1'b0) begin
        period[c] = cyc - last_end[c];
        last_end[c] = cyc;
        end_cnt[c]++;
      end
    end
  end
  // =====================================================================
  // Tasks
  // Waits for ready with no cycle limit; only the watchdog ends a hang
  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= is_wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
        @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Strobe counts are cleared only while every strobe is idle
  task automatic hold(input int c, input int n);
    foreach (ack_cnt[i]) begin
      ack_cnt[i] = 0;
      end_cnt[i] = 0;
    end
    want[c] <= 1'b1;
    pause(n);
    want[c] <= 1'b0;
    pause(12);
  endtask
  task automatic xfer(input int c, input logic [31:0] ctrl, input int ea, input int ee);
    wr(8'(4 * c), ctrl);
    hold(c, 1);
    wr(8'(4 * c), 32'h0000_0000);
    chk(ack_cnt[c], ea);
    chk(end_cnt[c], ee);
  endtask
  task automatic err_pulse(input logic use_nmi);
    addr_err <= ~use_nmi;
    nmi <= use_nmi;
    pause(1);
    addr_err <= 1'b0;
    nmi <= 1'b0;
    pause(2);
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // =====================================================================
  // Watchdog: the sequence needs well under 5000 cycles
  initial begin
    pause(20000);
    n_errors++;
    end_of_test();
  end
  // =====================================================================
  // Main sequence
  initial begin
    {rst, psel, penable, pwrite, addr_err, nmi} = 6'b100000;
    {paddr, pwdata, want, cyc} = '0;
    pause(4);
    rst <= 1'b0;
    pause(1);
    for (int i = 0; i < NUM_CH; i++) begin
      rd(8'(4 * i));
      chk(q, MODE_CTRL_RESET);
    end
    // Bit 28 is written zero throughout: software must not change it
    wr(OFF_MODE_CTRL1, 32'hec3c_0000);
    rd(OFF_MODE_CTRL1);
    chk(q & 32'hfffc_0000, 32'hec00_0000);
    wr(OFF_MODE_CTRL1, 32'h0000_0000);
    rd(8'h20);
    chk({31'h0, slv}, 32'h1);
    $display("Test registers done");
    xfer(0, 32'h8000_0000, 2, 1);
    xfer(1, 32'hc000_0000, 0, 1);
    xfer(1, 32'ha000_0000, 2, 0);
    wr(OFF_MODE_SEL, 32'h0000_0004);
    xfer(2, 32'h8000_0000, 0, 1);
    wr(OFF_MODE_SEL, 32'h0000_0000);
    xfer(0, 32'h0000_0000, 0, 0);
    $display("Test strobes done");
    // Pin already low when edge mode is enabled: first request taken on level
    want[3] <= 1'b1;
    pause(5);
    wr(OFF_MODE_CTRL3, 32'h8800_0000);
    hold(3, 30);
    chk(end_cnt[3], 1);
    hold(3, 1);
    chk(end_cnt[3], 1);
    wr(OFF_MODE_CTRL3, 32'h8000_0000);
    hold(3, 30);
    chk({31'h0, end_cnt[3] > 1}, 32'h1);
    p0 = period[3];
    wr(OFF_MODE_CTRL3, 32'h8400_0000);
    hold(3, 30);
    chk(period[3], p0 + 1);
    wr(OFF_MODE_CTRL3, 32'h0000_0000);
    wr(OFF_MODE_CTRL0, 32'h8000_0000);
    want[0] <= 1'b1;
    act = 1'b0;
    // Reads spaced four cycles apart so they cannot lock onto the idle phase
    repeat (6) begin
      rd(OFF_MODE_CTRL0);
      act = act | q[BIT_ACTIVE];
      pause(1);
    end
    want[0] <= 1'b0;
    pause(12);
    chk({31'h0, act}, 32'h1);
    rd(OFF_MODE_CTRL0);
    chk({31'h0, q[BIT_ACTIVE]}, 32'h0);
    $display("Test request detection done");
    rd(OFF_IRQ_STATUS);
    chk(q & 32'h0000_00f0, 32'h0000_00f0);
    wr(OFF_IRQ_ENABLE, 32'h0000_0000);
    pause(3);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_ENABLE, 32'h0000_0010);
    pause(3);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_CLEAR, 32'h0000_00f1);
    pause(3);
    chk({31'h0, irq}, 32'h0);
    rd(OFF_IRQ_STATUS);
    chk(q, 32'h0000_0000);
    $display("Test interrupts done");
    // A clearing write before the flag was read as one must not clear it
    err_pulse(1'b0);
    wr(OFF_MODE_CTRL0, 32'h0000_0000);
    rd(OFF_MODE_CTRL0);
    chk(q & 32'h8008_0000, 32'h0008_0000);
    wr(OFF_MODE_CTRL1, 32'h8000_0000);
    rd(OFF_MODE_CTRL1);
    chk(q & 32'h8008_0000, 32'h0000_0000);
    wr(OFF_MODE_CTRL0, 32'h8000_0000);
    rd(OFF_MODE_CTRL0);
    chk(q & 32'h8008_0000, 32'h0000_0000);
    wr(OFF_MODE_CTRL0, 32'h8008_0000);
    rd(OFF_MODE_CTRL0);
    chk(q & 32'h8008_0000, 32'h8000_0000);
    wr(OFF_MODE_SEL, 32'h0000_0010);
    err_pulse(1'b1);
    rd(OFF_MODE_CTRL0);
    chk(q & 32'h8008_0000, 32'h8000_0000);
    wr(OFF_MODE_SEL, 32'h0000_0000);
    err_pulse(1'b1);
    rd(OFF_MODE_CTRL0);
    chk(q & 32'h8008_0000, 32'h0008_0000);
    $display("Test system error done");
    end_of_test();
  end
endmodule // dmamc_top_test
